// [dtc_pkg.sv]
// Constants, types and register map of the dual timer/counter block.
// Function
// - Timer function counts every peripheral tick.
// - Counter samples pin, counts high-to-low pairs.
// - Counted edge appears next machine cycle.
// - Edge recognition takes two machine cycles.
// - Select bit picks timing or pin counting.
// - Gate bit adds high interrupt pin condition.
// - Mode is two low bits plus aux bit.
// - Mode 000 is prescaled thirteen-bit count.
// - Mode 001 is plain sixteen-bit count.
// - Mode 010 reloads low from high.
// - Timer zero split: low byte, high byte.
// - Timer one in split mode stops.
// - Mode 110 drives PWM on output pin.
// - Shared modes behave alike on both timers.
// - Optional output toggle on each timer's own overflow; split high byte overflow never toggles.
// - Thirteen-bit rollover sets the overflow flag.
// - PWM period 256, low time equals high byte, whole period at FF.
// - Toggle output starts high, needs timer function.
package dtc_pkg;
    // -----------------------------------------------------------------
    // Register indices; byte address is four times the index.
    // -----------------------------------------------------------------
    localparam int unsigned ADR_W = 10;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_AUX = 8'h8F;
    localparam logic [7:0] IDX_LO0 = 8'h8A;
    localparam logic [7:0] IDX_LO1 = 8'h8B;
    localparam logic [7:0] IDX_HI0 = 8'h8C;
    localparam logic [7:0] IDX_HI1 = 8'h8D;
    localparam logic [7:0] IDX_CTL = 8'h90;
    // -----------------------------------------------------------------
    // Field positions.
    // -----------------------------------------------------------------
    localparam int M_CT0 = 2;
    localparam int M_GT0 = 3;
    localparam int M_CT1 = 6;
    localparam int M_GT1 = 7;
    localparam int A_HI0 = 0;
    localparam int A_HI1 = 4;
    localparam int C_RUN0 = 0;
    localparam int C_RUN1 = 1;
    localparam int C_OVF0 = 2;
    localparam int C_OVF1 = 3;
    localparam int C_TOG0 = 4;
    localparam int C_TOG1 = 5;
    // -----------------------------------------------------------------
    // Reset values and timing.
    // -----------------------------------------------------------------
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [1:0] OUT_RST = 2'b11;
    localparam int unsigned MC_CLKS = 2;
    // -----------------------------------------------------------------
    // Types.
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        MD_PRE13 = 3'b000,
        MD_16 = 3'b001,
        MD_RLD = 3'b010,
        MD_SPLIT = 3'b011,
        MD_PWM = 3'b110
    } dtc_mode_t;
    // Pins from the outside: count inputs and external interrupt levels.
    typedef struct packed {
        logic [1:0] cnt;
        logic [1:0] irq;
    } dtc_pin_t;
    // Whole state of the block.
    typedef struct packed {
        logic mc;
        logic [7:0] mode_ctl;
        logic [1:0] aux_mode;
        logic [5:0] ctl;
        logic [7:0] lo0;
        logic [7:0] hi0;
        logic [7:0] lo1;
        logic [7:0] hi1;
        logic [1:0] smp;
        logic [1:0] pend;
        logic [1:0] tog;
        logic [1:0] pout;
        logic ack;
        logic [7:0] rdat;
    } dtc_state_t;
endpackage : dtc_pkg

// [dtc_top.sv]
// Dual 16-bit timer/counter with a classic Wishbone register slave.
`timescale 1ns/100ps
module dtc_top (
    // Clock and reset.
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Wishbone slave.
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [dtc_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Count and gate pins.
    input wire dtc_pkg::dtc_pin_t PIN_I,
    // Timer output pins.
    output logic [1:0] TOUT_O,
    output logic [1:0] TOUT_OE_O
);
    import dtc_pkg::*;

    // -----------------------------------------------------------------
    // Helper functions.
    // -----------------------------------------------------------------
    // Mode of timer n from the low pair and the auxiliary bit.
    function automatic logic [2:0] get_mode(input logic [7:0] mc,
                                            input logic [1:0] ax,
                                            input logic n);
        get_mode = n ? {ax[1], mc[5:4]} : {ax[0], mc[1:0]};
    endfunction

    // One count step shared by both timers: {overflow, high, low}.
    // Reserved codes simply hold, so a stray code cannot run away.
    function automatic logic [16:0] step(input logic [2:0] md,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi,
                                         input logic en);
        logic [13:0] c13;
        logic [16:0] c16;
        c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        c16 = {1'b0, hi, lo} + 17'h0_0001;
        step = {1'b0, hi, lo};
        if (en) begin
            case (md)
                MD_PRE13: step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
                MD_16: step = c16;
                MD_RLD: step = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
                MD_SPLIT: step = {(lo == 8'hFF), hi, lo + 8'h01};
                MD_PWM: step = {1'b0, hi, lo + 8'h01};
                default: step = {1'b0, hi, lo};
            endcase
        end
    endfunction

    // PWM level: low while the low count is below the high byte; always low at FF.
    function automatic logic pwm_lvl(input logic [7:0] lo, input logic [7:0] hi);
        if (hi == 8'h00) begin
            pwm_lvl = 1'b1;
        end else if (hi == 8'hFF) begin
            pwm_lvl = 1'b0;
        end else begin
            pwm_lvl = (lo >= hi);
        end
    endfunction

    // -----------------------------------------------------------------
    // State and decoded terms.
    // -----------------------------------------------------------------
    dtc_state_t s_reg; // Registered state.
    dtc_state_t s_next; // Next state.
    logic tick; // One machine cycle strobe, every second clock.
    logic [2:0] md0; // Mode of timer zero.
    logic [2:0] md1; // Mode of timer one.
    logic ct0; // Timer zero counts pin edges.
    logic ct1; // Timer one counts pin edges.
    logic gt0; // Timer zero gate enable.
    logic gt1; // Timer one gate enable.
    logic en0; // Timer zero step this cycle.
    logic en1; // Timer one step this cycle.
    logic enh; // Split high byte step this cycle.
    logic ovf0_ev; // Timer zero overflow event.
    logic ovf1_ev; // Timer one overflow event.
    logic ovfh_ev; // Split high byte overflow event.
    logic [16:0] r0; // Step result of timer zero.
    logic [16:0] r1; // Step result of timer one.
    logic req; // New bus request.
    logic wr; // Write on byte lane zero.
    logic [7:0] idx; // Register index.
    logic [7:0] wd; // Write data byte.
    logic [15:0] cnt0; // Timer zero as one word.
    logic [15:0] cnt1; // Timer one as one word.

    assign cnt0 = {s_reg.hi0, s_reg.lo0};
    assign cnt1 = {s_reg.hi1, s_reg.lo1};

    // -----------------------------------------------------------------
    // Next-state logic.
    // -----------------------------------------------------------------
    // Everything is computed here from the registered copy; the bus
    // write of a byte wins over a count step of that same byte.
    always_comb begin
        s_next = s_reg;
        tick = s_reg.mc;
        s_next.mc = ~s_reg.mc;
        idx = WB_ADR_I[9:2];
        wd = WB_DAT_I[7:0];
        req = WB_CYC_I && WB_STB_I && !s_reg.ack;
        wr = req && WB_WE_I && WB_SEL_I[0];
        md0 = get_mode(s_reg.mode_ctl, s_reg.aux_mode, 1'b0);
        md1 = get_mode(s_reg.mode_ctl, s_reg.aux_mode, 1'b1);
        ct0 = s_reg.mode_ctl[M_CT0];
        ct1 = s_reg.mode_ctl[M_CT1];
        gt0 = s_reg.mode_ctl[M_GT0];
        gt1 = s_reg.mode_ctl[M_GT1];
        // Sample the count pins once per machine cycle; a high sample
        // followed by a low one arms a step for the next cycle.
        if (tick) begin
            s_next.smp = PIN_I.cnt;
            s_next.pend = s_reg.smp & ~PIN_I.cnt;
        end
        // Enables: run, optional gate level, then tick or pin edge.
        en0 = tick && s_reg.ctl[C_RUN0] && (!gt0 || PIN_I.irq[0])
              && (ct0 ? s_reg.pend[0] : 1'b1);
        en1 = tick && s_reg.ctl[C_RUN1] && (!gt1 || PIN_I.irq[1])
              && (ct1 ? s_reg.pend[1] : 1'b1)
              && (md1 != MD_SPLIT);
        // The split high byte always times and borrows timer one's run.
        enh = tick && (md0 == MD_SPLIT) && s_reg.ctl[C_RUN1];
        r0 = step(md0, s_reg.lo0, s_reg.hi0, en0);
        r1 = step(md1, s_reg.lo1, s_reg.hi1, en1);
        ovf0_ev = r0[16];
        ovf1_ev = r1[16];
        ovfh_ev = enh && (s_reg.hi0 == 8'hFF);
        s_next.lo0 = r0[7:0];
        s_next.hi0 = enh ? s_reg.hi0 + 8'h01 : r0[15:8];
        s_next.lo1 = r1[7:0];
        s_next.hi1 = r1[15:8];
        // Bus writes to the count bytes override the step.
        if (wr) begin
            case (idx)
                IDX_MODE: s_next.mode_ctl = wd;
                IDX_AUX: s_next.aux_mode = {wd[A_HI1], wd[A_HI0]};
                IDX_LO0: s_next.lo0 = wd;
                IDX_HI0: s_next.hi0 = wd;
                IDX_LO1: s_next.lo1 = wd;
                IDX_HI1: s_next.hi1 = wd;
                IDX_CTL: s_next.ctl = wd[5:0];
                default: s_next.ctl = s_reg.ctl;
            endcase
        end
        // Overflow flags: a hardware set wins over a software clear.
        // In PWM mode the flag simply follows the PWM level.
        s_next.ctl[C_OVF0] = s_next.ctl[C_OVF0] | ovf0_ev;
        if (md0 == MD_PWM) begin
            s_next.ctl[C_OVF0] = pwm_lvl(s_reg.lo0, s_reg.hi0);
        end
        // With timer zero split, timer one loses its flag to the high byte.
        if (md0 == MD_SPLIT) begin
            s_next.ctl[C_OVF1] = s_next.ctl[C_OVF1] | ovfh_ev;
        end else begin
            s_next.ctl[C_OVF1] = s_next.ctl[C_OVF1] | ovf1_ev;
        end
        if (md1 == MD_PWM) begin
            s_next.ctl[C_OVF1] = pwm_lvl(s_reg.lo1, s_reg.hi1);
        end
        // Toggle outputs rest at one until enabled and overflowing.
        // Counter function blocks toggling, as the pin is then an input.
        if (!s_reg.ctl[C_TOG0] || ct0) begin
            s_next.tog[0] = 1'b1;
        end else if (ovf0_ev) begin
            s_next.tog[0] = ~s_reg.tog[0];
        end
        if (!s_reg.ctl[C_TOG1] || ct1) begin
            s_next.tog[1] = 1'b1;
        end else if (ovf1_ev) begin
            s_next.tog[1] = ~s_reg.tog[1];
        end
        // Pin level: PWM level in mode 110, else the toggle state.
        s_next.pout[0] = (md0 == MD_PWM) ? pwm_lvl(s_reg.lo0, s_reg.hi0) : s_reg.tog[0];
        s_next.pout[1] = (md1 == MD_PWM) ? pwm_lvl(s_reg.lo1, s_reg.hi1) : s_reg.tog[1];
        // Bus answer: one ack per request, read data from flops.
        // Unmapped indices read zero and ignore writes.
        s_next.ack = req;
        if (req) begin
            case (idx)
                IDX_MODE: s_next.rdat = s_reg.mode_ctl;
                IDX_AUX: s_next.rdat = {3'b000, s_reg.aux_mode[1], 3'b000, s_reg.aux_mode[0]};
                IDX_LO0: s_next.rdat = s_reg.lo0;
                IDX_HI0: s_next.rdat = s_reg.hi0;
                IDX_LO1: s_next.rdat = s_reg.lo1;
                IDX_HI1: s_next.rdat = s_reg.hi1;
                IDX_CTL: s_next.rdat = {2'b00, s_reg.ctl};
                default: s_next.rdat = 8'h00;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // State register.
    // -----------------------------------------------------------------
    // Asynchronous reset loads constants only.
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            s_reg <= '0;
            s_reg.mode_ctl <= MODE_RST;
            s_reg.lo0 <= CNT_RST;
            s_reg.hi0 <= CNT_RST;
            s_reg.lo1 <= CNT_RST;
            s_reg.hi1 <= CNT_RST;
            s_reg.tog <= OUT_RST;
            s_reg.pout <= OUT_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // -----------------------------------------------------------------
    // Outputs.
    // -----------------------------------------------------------------
    assign WB_ACK_O = s_reg.ack;
    assign WB_DAT_O = {24'h00_0000, s_reg.rdat};
    assign TOUT_O = s_reg.pout;
    // The pin is driven in PWM mode or while toggling is enabled with timer function.
    assign TOUT_OE_O[0] = (md0 == MD_PWM) || (s_reg.ctl[C_TOG0] && !ct0);
    assign TOUT_OE_O[1] = (md1 == MD_PWM) || (s_reg.ctl[C_TOG1] && !ct1);

    // -----------------------------------------------------------------
    // Assertions and covers.
    // -----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RST_I);

    logic wr_any; // Any bus write in flight.
    assign wr_any = WB_CYC_I && WB_STB_I && WB_WE_I;

    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    ack_next_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing one cycle after request");
    timer_rate_a: assert property (tick && md0 == MD_16 && !ct0 && !gt0
        && s_reg.ctl[C_RUN0] && !wr_any |=> cnt0 == $past(cnt0) + 16'h0001)
        else $error("timer did not step on tick");
    edge_arm_a: assert property (tick && s_reg.smp[0] && !PIN_I.cnt[0]
        |=> (s_reg.pend[0] && !tick) ##1 (s_reg.pend[0] && tick))
        else $error("falling edge not armed");
    edge_count_a: assert property (tick && md0 == MD_16 && ct0 && !gt0
        && s_reg.ctl[C_RUN0] && s_reg.pend[0] && !wr_any
        |=> cnt0 == $past(cnt0) + 16'h0001)
        else $error("armed edge not counted");
    gate_hold_a: assert property (gt0 && !PIN_I.irq[0] && md0 == MD_16
        && !wr_any |=> $stable(cnt0))
        else $error("gated timer moved");
    t1_stop_a: assert property (md1 == MD_SPLIT && !wr_any |=> $stable(cnt1))
        else $error("timer one ran in split mode");
    reload_a: assert property (md0 == MD_RLD && en0 && s_reg.lo0 == 8'hFF
        && !wr_any |=> s_reg.lo0 == $past(s_reg.hi0) && s_reg.ctl[C_OVF0])
        else $error("reload or flag missing");
    pre13_a: assert property (md0 == MD_PRE13 && en0 && s_reg.hi0 == 8'hFF
        && s_reg.lo0[4:0] == 5'h1F && !wr_any
        |=> s_reg.hi0 == 8'h00 && s_reg.lo0[4:0] == 5'h00 && s_reg.ctl[C_OVF0])
        else $error("thirteen-bit rollover wrong");
    pwm_low_a: assert property (md0 == MD_PWM && s_reg.hi0 == 8'h40
        && s_reg.lo0 < 8'h40 |=> !TOUT_O[0])
        else $error("PWM not low below high byte");
    tog_flip_a: assert property (ovf0_ev && s_reg.ctl[C_TOG0] && !ct0
        && !wr_any |=> s_reg.tog[0] != $past(s_reg.tog[0]))
        else $error("toggle missed on overflow");

    // -----------------------------------------------------------------
    // Rule checks on flags, split mode, PWM, toggle, pin counting and timer one.
    // -----------------------------------------------------------------
    // A hardware overflow sets the flag even when software clears it.
    ovf_set_a: assert property (ovf0_ev && md0 != MD_PWM
        |=> s_reg.ctl[C_OVF0])
        else $error("overflow flag not set");
    // The split high byte wraps on its own and raises timer one's flag.
    split_high_a: assert property (enh && s_reg.hi0 == 8'hFF && md1 != MD_PWM
        && !wr_any |=> s_reg.hi0 == 8'h00 && s_reg.ctl[C_OVF1])
        else $error("split high byte overflow wrong");
    // In PWM mode the flag is high once the low count reaches a high byte below FF.
    pwm_flag_a: assert property (md0 == MD_PWM && s_reg.hi0 == 8'h40
        && s_reg.lo0 >= 8'h40 |=> s_reg.ctl[C_OVF0])
        else $error("PWM flag not high");
    // Counter function parks the toggle state at one.
    tog_rest_a: assert property (ct0 |=> s_reg.tog[0])
        else $error("toggle not parked high");
    // Counter function ignores the clock while no edge is armed.
    count_hold_a: assert property (tick && md0 == MD_16 && ct0
        && !s_reg.pend[0] && !wr_any |=> $stable(cnt0))
        else $error("counter moved without edge");
    // Timer one counts pin edges the same way as timer zero.
    t1_edge_a: assert property (tick && md1 == MD_16 && ct1 && !gt1
        && s_reg.ctl[C_RUN1] && s_reg.pend[1] && !wr_any
        |=> cnt1 == $past(cnt1) + 16'h0001)
        else $error("timer one edge not counted");

    split_c: cover property (md0 == MD_SPLIT && ovfh_ev);
    edge_c: cover property (tick && ct0 && s_reg.pend[0] && en0);
    pwm_c: cover property (md1 == MD_PWM && TOUT_O[1] ##1 !TOUT_O[1]);
    read_c: cover property (WB_CYC_I && WB_STB_I && !WB_WE_I ##1 WB_ACK_O);
endmodule // dtc_top

// [dtc_pins_model.sv]
// Behavioural model of the count pins and gate pins outside the timer block.
`timescale 1ns/100ps
module dtc_pins_model (
    // Clock of the driven domain.
    input wire logic clk_i,
    // Levels driven onto the count and gate pins.
    output dtc_pkg::dtc_pin_t pins_o
);
    import dtc_pkg::*;
    // -----------------------------------------------------------------
    // Idle levels: count pins low, gates closed.
    // -----------------------------------------------------------------
    initial begin
        pins_o = '0;
    end
    // Each level is held for exactly one machine cycle of two clocks, the shortest
    // hold that still guarantees one sample per level, so edges come at top rate.
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            @(posedge clk_i);
            pins_o.cnt[ch] <= 1'b1;
            repeat (2) @(posedge clk_i);
            pins_o.cnt[ch] <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    // Gate levels change just after a clock edge.
    task automatic set_irq(input logic [1:0] v);
        @(posedge clk_i);
        pins_o.irq <= v;
    endtask
endmodule // dtc_pins_model

// [dtc_top_test.sv]
// Self-checking bench for the dual timer/counter with its Wishbone register slave.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module dtc_top_test;
    import dtc_pkg::*;
    // -----------------------------------------------------------------
    // Signals toward the design.
    // -----------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [1:0] tout;
    logic [1:0] toe;
    dtc_pin_t pins;
    int err_total = 0;
    int checks = 0;
    logic [7:0] rd;
    int lows;
    int lows1;
    // Overflow cases: 16-bit, 13-bit prescaled and 8-bit reload.
    logic [2:0] ov_md [3] = '{3'b001, 3'b000, 3'b010};
    logic [7:0] ov_lo [3] = '{8'hF0, 8'h1C, 8'hF0};
    logic [7:0] ov_hi [3] = '{8'hFF, 8'hFF, 8'h80};
    logic [7:0] ov_eh [3] = '{8'h00, 8'h00, 8'h80};
    // PWM cases: high byte and low clocks seen over one 512-clock period.
    logic [7:0] pw_hi [3] = '{8'h00, 8'h40, 8'hFF};
    int pw_lo [3] = '{0, 128, 512};
    // -----------------------------------------------------------------
    // Clock, design and pin model.
    // -----------------------------------------------------------------
    initial begin
        forever #2 clk = ~clk;
    end
    dtc_top dtc_top_inst (.CLK_SYS_I(clk), .RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .PIN_I(pins), .TOUT_O(tout), .TOUT_OE_O(toe));
    dtc_pins_model dtc_pins_model_inst (.clk_i(clk), .pins_o(pins));
    // -----------------------------------------------------------------
    // Verdict and bus tasks.
    // -----------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One classic cycle; the request is held until ack is sampled high, so a
    // slow slave is tolerated and only the bounded wait ends a hang.
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= {idx, 2'b00};
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic cfg(input logic [7:0] md, ax, l0, h0);
        wb(1'b1, IDX_MODE, md);
        wb(1'b1, IDX_AUX, ax);
        wb(1'b1, IDX_LO0, l0);
        wb(1'b1, IDX_HI0, h0);
    endtask
    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask
    // -----------------------------------------------------------------
    // Main sequence.
    // -----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Reset values, reserved aux bits and an unmapped place.
        foreach (ov_lo[i]) begin
            wb(1'b0, i == 0 ? IDX_MODE : (i == 1 ? IDX_AUX : IDX_LO0), 8'h00);
            `CHK("reset value", 8'h00, rd)
        end
        `CHK("tout reset", 2'b11, tout)
        `CHK("oe reset", 2'b00, toe)
        wb(1'b1, IDX_AUX, 8'hFF);
        wb(1'b0, IDX_AUX, 8'h00);
        `CHK("aux bits", 8'h11, rd)
        wb(1'b1, 8'h00, 8'h5A);
        wb(1'b0, 8'h00, 8'h00);
        `CHK("unmapped", 8'h00, rd)
        done("registers");
        // Overflow in modes 001, 000 and 010; code bit 2 lives in the aux register.
        foreach (ov_md[i]) begin
            cfg({6'b0, ov_md[i][1:0]}, {7'b0, ov_md[i][2]}, ov_lo[i], ov_hi[i]);
            wb(1'b1, IDX_CTL, 8'h01);
            repeat (60) @(posedge clk);
            wb(1'b0, IDX_CTL, 8'h00);
            `CHK("ovf flag", 1'b1, rd[C_OVF0])
            wb(1'b1, IDX_CTL, 8'h00);
            wb(1'b0, IDX_HI0, 8'h00);
            `CHK("high byte", ov_eh[i], rd)
            wb(1'b0, IDX_LO0, 8'h00);
            if (ov_md[i] != 3'b000) begin
                `CHK("low msb", ov_md[i][1], rd[7])
            end
        end
        done("overflow");
        // Gate closed holds the count, gate open lets it run.
        cfg(8'h09, 8'h00, 8'h00, 8'h00);
        wb(1'b1, IDX_CTL, 8'h01);
        repeat (40) @(posedge clk);
        wb(1'b0, IDX_LO0, 8'h00);
        `CHK("gate closed", 8'h00, rd)
        dtc_pins_model_inst.set_irq(2'b01);
        repeat (40) @(posedge clk);
        wb(1'b0, IDX_LO0, 8'h00);
        `CHK("gate open", 1'b1, rd != 8'h00)
        dtc_pins_model_inst.set_irq(2'b00);
        wb(1'b1, IDX_CTL, 8'h00);
        done("gate");
        // Split mode: timer one run drives high byte zero, timer one stands.
        cfg(8'h33, 8'h00, 8'h00, 8'hF8);
        wb(1'b1, IDX_LO1, 8'h00);
        wb(1'b1, IDX_HI1, 8'h00);
        wb(1'b1, IDX_CTL, 8'h02);
        repeat (40) @(posedge clk);
        wb(1'b0, IDX_CTL, 8'h00);
        `CHK("split flag", 1'b1, rd[C_OVF1])
        wb(1'b1, IDX_CTL, 8'h00);
        wb(1'b0, IDX_LO0, 8'h00);
        `CHK("split low", 8'h00, rd)
        wb(1'b0, IDX_HI0, 8'h00);
        `CHK("split high", 1'b1, rd != 8'h00)
        wb(1'b0, IDX_LO1, 8'h00);
        `CHK("t1 stopped", 8'h00, rd)
        done("split");
        // Pin counting on both timers at the top edge rate.
        for (int ch = 0; ch < 2; ch++) begin
            wb(1'b1, IDX_MODE, ch == 1 ? 8'h50 : 8'h05);
            wb(1'b1, IDX_AUX, 8'h00);
            wb(1'b1, ch == 1 ? IDX_LO1 : IDX_LO0, 8'h00);
            wb(1'b1, IDX_CTL, ch == 1 ? 8'h02 : 8'h01);
            dtc_pins_model_inst.pulse(ch, 5);
            repeat (8) @(posedge clk);
            wb(1'b0, ch == 1 ? IDX_LO1 : IDX_LO0, 8'h00);
            `CHK("edges", 8'h05, rd)
            wb(1'b1, IDX_CTL, 8'h00);
        end
        done("counter");
        // Toggle output rests high, flips on overflow, needs timer function.
        cfg(8'h01, 8'h00, 8'hF0, 8'hFF);
        wb(1'b1, IDX_CTL, 8'h11);
        `CHK("tog start", 2'b11, {tout[0], toe[0]})
        repeat (60) @(posedge clk);
        `CHK("tog flip", 1'b0, tout[0])
        wb(1'b1, IDX_MODE, 8'h05);
        `CHK("tog counter", 1'b0, toe[0])
        wb(1'b1, IDX_CTL, 8'h00);
        done("toggle");
        // PWM low time over one full period for both forced and mid values.
        foreach (pw_hi[i]) begin
            cfg(8'h22, 8'h11, 8'h00, pw_hi[i]);
            wb(1'b1, IDX_HI1, pw_hi[i]);
            wb(1'b1, IDX_CTL, 8'h03);
            repeat (520) @(posedge clk);
            lows = 0;
            lows1 = 0;
            repeat (512) begin
                @(posedge clk);
                if (tout[0] === 1'b0) lows++;
                if (tout[1] === 1'b0) lows1++;
            end
            `CHK("pwm low", pw_lo[i], lows)
            `CHK("pwm low t1", pw_lo[i], lows1)
            `CHK("pwm oe", 2'b11, toe)
        end
        done("pwm");
        summarize();
    end
endmodule // dtc_top_test
